/* File: dcip_node.sv */
package dcip_pkg;
  // -----------------------------------------------------------------
  // Widths, counts and timing of the acknowledge cycle
  // -----------------------------------------------------------------
  localparam int unsigned VEC_W = 8;
  localparam int unsigned N_PERIPH_DEF = 4;
  localparam int unsigned CNT_W = 3;
  // Three base clocks of the fetch plus two inserted waits.
  localparam logic [2:0] ACK_T_BASE = 3'h3;
  localparam logic [2:0] ACK_WAITS = 3'h2;
  localparam logic [2:0] ACK_LAST = 3'(ACK_T_BASE + ACK_WAITS - 3'h1);
  localparam logic [2:0] IO_STB_FIRST = 3'h2;
  localparam logic [2:0] IO_STB_LAST = 3'h3;
  localparam logic [2:0] CNT_RST = 3'h0;
  localparam logic [VEC_W-1:0] VEC_RST = 8'h00;
  localparam logic LATCH_RST = 1'b0;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_ACK = 2'b10
  } dcip_state_e;
endpackage

module dcip_node (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  // Peripheral side
  input wire logic req_i,
  input wire logic [dcip_pkg::VEC_W-1:0] vec_i,
  // Chain
  input wire logic chain_enable_in_i,
  output logic chain_enable_out_o,
  // Processor side
  input wire logic ack_i,
  input wire logic ack_commit_i,
  input wire logic service_done_i,
  output logic irq_o,
  output logic vec_drive_o,
  output logic [dcip_pkg::VEC_W-1:0] vec_o
);
  typedef struct packed {
    logic pend;
    logic svc;
  } dcip_node_s;

  dcip_node_s q, d;

  always_comb begin
    d = q;
    if (ack_commit_i && chain_enable_in_i && q.pend) begin
      d.svc = 1'b1;
      d.pend = 1'b0;
    end
    if (service_done_i && chain_enable_in_i && q.svc) begin
      d.svc = 1'b0;
    end
    // A new event in the commit cycle stays pending: the set wins.
    if (req_i) begin
      d.pend = 1'b1;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      q <= '0;
    end else if (ce_i) begin
      q <= d;
    end
  end

  // Pending also blocks, so a lower device cannot answer the same acknowledge.
  assign chain_enable_out_o = chain_enable_in_i && !q.pend && !q.svc;
  assign irq_o = q.pend && chain_enable_in_i;
  assign vec_drive_o = ack_i && chain_enable_in_i && q.pend;
  assign vec_o = vec_drive_o ? vec_i : dcip_pkg::VEC_RST;

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);

  AST_OUT_BLOCK: assert property ((q.pend || q.svc) |-> !chain_enable_out_o)
    else $error("chain enable out active while pending or in service");
  AST_IN_GATE: assert property (!chain_enable_in_i |-> !chain_enable_out_o && !vec_drive_o)
    else $error("disabled node passes enable or drives vector");
  AST_OUT_RELEASE: assert property (ce_i && q.svc && service_done_i && chain_enable_in_i
      && !q.pend && !req_i ##1 chain_enable_in_i |-> chain_enable_out_o)
    else $error("chain enable out not raised after service end");
  AST_VEC_ONLY: assert property (vec_drive_o |-> chain_enable_in_i && q.pend && ack_i)
    else $error("vector driven without enable and pending request");
  AST_QUEUE: assert property (q.pend && !(ack_commit_i && chain_enable_in_i) |=> q.pend)
    else $error("pending request lost");
endmodule

/* File: dcip_top.sv */
// Function
// - Each chain node has an enable input and an enable output that feeds the next lower node.
// - Priority follows position, the first node ranking highest.
// - Among simultaneous requesters only the highest one is selected.
// - A node that has raised a request keeps its enable output low until its service ends.
// - When service ends and no request of its own is pending or arriving, the node raises its enable output again.
// - Pending requests and requests arriving during service are queued, not dropped.
// - Two accept latches, main and shadow; only main gates acceptance of maskable requests, and shadow holds a copy of it.
// - A maskable request is acknowledged by a fetch cycle with the I/O strobe instead of the memory strobe and two waits.
// - Nodes share the maskable request line as a wired-OR.
// - Both request lines are sampled at the clock that ends an instruction.
module dcip_top #(
  parameter int unsigned N_PERIPH = dcip_pkg::N_PERIPH_DEF
) (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  // Peripherals
  input wire logic [N_PERIPH-1:0] periph_req_i,
  input wire logic [N_PERIPH*dcip_pkg::VEC_W-1:0] periph_vec_i,
  input wire logic chain_enable_head_i,
  output logic chain_enable_out_o,
  // Core instruction events
  input wire logic instr_end_i,
  input wire logic nmi_i,
  input wire logic enable_irq_i,
  input wire logic disable_irq_i,
  input wire logic retn_i,
  input wire logic reti_i,
  input wire logic mem_req_core_i,
  // Bus strobes
  output logic opcode_fetch_cycle_o,
  output logic io_request_strobe_o,
  output logic memory_request_strobe_o,
  // Status and results
  output logic irq_line_o,
  output logic irq_accept_latch_main_o,
  output logic irq_accept_latch_shadow_o,
  output logic nmi_take_o,
  output logic vector_valid_o,
  output logic [dcip_pkg::VEC_W-1:0] vector_o
);
  localparam int unsigned VW = dcip_pkg::VEC_W;

  if (N_PERIPH < 1) begin : g_chk
    $error("N_PERIPH must be at least one");
  end

  typedef struct packed {
    dcip_pkg::dcip_state_e st;
    logic [dcip_pkg::CNT_W-1:0] cnt;
    logic main;
    logic shadow;
    logic [VW-1:0] vec;
    logic vec_valid;
    logic nmi_take;
  } dcip_top_s;

  dcip_top_s q, d;

  logic [N_PERIPH:0] chain;
  logic [N_PERIPH-1:0] irq;
  logic [N_PERIPH-1:0] drive;
  logic [VW-1:0] node_vec [N_PERIPH];
  logic [VW-1:0] bus_vec;
  logic int_line;
  logic in_ack;
  logic ack_strobe;
  logic ack_commit;
  logic take_int;

  // -----------------------------------------------------------------
  // Priority chain
  // -----------------------------------------------------------------
  // The head enable is an input so a larger chain can be cascaded.
  assign chain[0] = chain_enable_head_i;

  for (genvar i = 0; i < N_PERIPH; i++) begin : g_node
    dcip_node u_node (
      .clk_sys_i(clk_sys_i),
      .rst_n_i(rst_n_i),
      .ce_i(ce_i),
      .req_i(periph_req_i[i]),
      .vec_i(periph_vec_i[i*VW +: VW]),
      .chain_enable_in_i(chain[i]),
      .chain_enable_out_o(chain[i+1]),
      .ack_i(ack_strobe),
      .ack_commit_i(ack_commit),
      .service_done_i(reti_i),
      .irq_o(irq[i]),
      .vec_drive_o(drive[i]),
      .vec_o(node_vec[i])
    );
  end

  // Only one node can drive, so an OR of the gated vectors is the bus.
  always_comb begin
    bus_vec = '0;
    for (int i = 0; i < N_PERIPH; i++) begin
      bus_vec = bus_vec | node_vec[i];
    end
  end

  assign int_line = |irq;
  assign chain_enable_out_o = chain[N_PERIPH];

  // -----------------------------------------------------------------
  // Acceptance and acknowledge sequencing
  // -----------------------------------------------------------------
  assign in_ack = (q.st == dcip_pkg::ST_ACK);
  assign ack_strobe = in_ack && (q.cnt >= dcip_pkg::IO_STB_FIRST)
      && (q.cnt <= dcip_pkg::IO_STB_LAST);
  assign ack_commit = in_ack && (q.cnt == dcip_pkg::IO_STB_LAST);
  assign take_int = (q.st == dcip_pkg::ST_IDLE) && instr_end_i && !nmi_i && int_line && q.main;

  always_comb begin
    d = q;
    d.vec_valid = 1'b0;
    d.nmi_take = 1'b0;
    unique case (q.st)
      dcip_pkg::ST_IDLE: begin
        if (enable_irq_i) begin
          d.main = 1'b1;
          d.shadow = 1'b1;
        end
        if (disable_irq_i) begin
          d.main = 1'b0;
          d.shadow = 1'b0;
        end
        if (retn_i) begin
          d.main = q.shadow;
        end
        // The lines are looked at only on the closing clock of an instruction.
        if (instr_end_i && nmi_i) begin
          d.nmi_take = 1'b1;
          d.shadow = q.main;
          d.main = 1'b0;
        end else if (take_int) begin
          d.st = dcip_pkg::ST_ACK;
          d.cnt = dcip_pkg::CNT_RST;
          d.main = 1'b0;
          d.shadow = 1'b0;
        end
      end
      dcip_pkg::ST_ACK: begin
        d.cnt = q.cnt + 3'h1;
        if (q.cnt == dcip_pkg::IO_STB_LAST) begin
          d.vec = bus_vec;
        end
        if (q.cnt == dcip_pkg::ACK_LAST) begin
          d.st = dcip_pkg::ST_IDLE;
          d.vec_valid = 1'b1;
        end
      end
    endcase
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      q.st <= dcip_pkg::ST_IDLE;
      q.cnt <= dcip_pkg::CNT_RST;
      q.main <= dcip_pkg::LATCH_RST;
      q.shadow <= dcip_pkg::LATCH_RST;
      q.vec <= dcip_pkg::VEC_RST;
      q.vec_valid <= 1'b0;
      q.nmi_take <= 1'b0;
    end else if (ce_i) begin
      q <= d;
    end
  end

  assign opcode_fetch_cycle_o = in_ack;
  assign io_request_strobe_o = ack_strobe;
  assign memory_request_strobe_o = mem_req_core_i && !in_ack;
  assign irq_line_o = int_line;
  assign irq_accept_latch_main_o = q.main;
  assign irq_accept_latch_shadow_o = q.shadow;
  assign nmi_take_o = q.nmi_take;
  assign vector_valid_o = q.vec_valid;
  assign vector_o = q.vec;

  // -----------------------------------------------------------------
  // Checks
  // -----------------------------------------------------------------
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);

  sequence s_accept;
    ce_i && take_int;
  endsequence

  sequence s_ack_body;
    opcode_fetch_cycle_o && !io_request_strobe_o ##1
    opcode_fetch_cycle_o && !io_request_strobe_o ##1
    opcode_fetch_cycle_o && io_request_strobe_o;
  endsequence

  AST_ONE_DRIVER: assert property ($onehot0(drive))
    else $error("more than one node drives a vector");
  AST_ACK_SHAPE: assert property (s_accept ##1 ce_i[*3] |-> $past(io_request_strobe_o, 1) == 1'b0)
    else $error("I/O strobe asserted before the waits");
  AST_ACK_START: assert property (s_accept |=> s_ack_body or !ce_i)
    else $error("acknowledge cycle shape wrong");
  AST_NO_MEM_STB: assert property (opcode_fetch_cycle_o |-> !memory_request_strobe_o)
    else $error("memory strobe during acknowledge");
  AST_LATCH_CLEAR: assert property (s_accept |=> !irq_accept_latch_main_o
      && !irq_accept_latch_shadow_o)
    else $error("accept latches not cleared on acceptance");
  AST_SAMPLE_END: assert property ($rose(opcode_fetch_cycle_o) |-> $past(instr_end_i && ce_i))
    else $error("acknowledge started outside instruction end");
  AST_MASKED: assert property (!irq_accept_latch_main_o && !opcode_fetch_cycle_o
      |=> !opcode_fetch_cycle_o)
    else $error("request accepted with main latch clear");
  // A raised request line must come from a node that also blocks the chain's tail.
  AST_WIRED_OR: assert property (irq_line_o |-> !chain_enable_out_o)
    else $error("request line high while the chain tail is enabled");
  AST_HEAD_PRIO: assert property (ack_strobe && irq[0] |-> drive[0] && $onehot(drive))
    else $error("head node request not answered by the head alone");
endmodule

/* File: dcip_core_model.sv */
module dcip_core_model (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  // Core events
  output logic instr_end_o,
  output logic mem_req_core_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] cnt_q;
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      cnt_q <= 2'h0;
    end else begin
      cnt_q <= cnt_q + 2'h1;
    end
  end
  // Every fourth clock ends an instruction, so requests are sampled there only.
  assign instr_end_o = (cnt_q == 2'h3);
  assign mem_req_core_o = cnt_q[0];
endmodule

/* File: daisy_chain_interrupt_priority_tb_top.sv */
module daisy_chain_interrupt_priority_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int N = 4;
  logic clk_sys_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic ce = 1'b1;
  logic [N-1:0] req = '0;
  logic [N*8-1:0] vecs_in = '0;
  logic nmi = 1'b0;
  logic [3:0] ev = 4'h0;
  logic iend, memory_request_strobe, chain, fetch, io, mem, irq, main, shadow, take, vv;
  logic [7:0] vec;
  int errors = 0;
  int comparisons = 0;
  int cycles = 0;
  int fcnt = 0;
  int iocnt = 0;

  always #10 clk_sys_i = ~clk_sys_i;

  dcip_core_model core (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .instr_end_o(iend),
    .mem_req_core_o(memory_request_strobe));

  // The head of the chain is tied enabled, as the system must do.
  dcip_top #(.N_PERIPH(N)) uut (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .ce_i(ce),
    .periph_req_i(req), .periph_vec_i(vecs_in), .chain_enable_head_i(1'b1),
    .chain_enable_out_o(chain), .instr_end_i(iend), .nmi_i(nmi), .enable_irq_i(ev[0]),
    .disable_irq_i(ev[1]), .retn_i(ev[2]), .reti_i(ev[3]), .mem_req_core_i(memory_request_strobe),
    .opcode_fetch_cycle_o(fetch), .io_request_strobe_o(io), .memory_request_strobe_o(mem),
    .irq_line_o(irq), .irq_accept_latch_main_o(main), .irq_accept_latch_shadow_o(shadow),
    .nmi_take_o(take), .vector_valid_o(vv), .vector_o(vec));

  // ------------------------------------------------------------
  // Checking and closing
  // ------------------------------------------------------------
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic conclude;
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // The highest pending node is the lowest set bit of the still-waiting mask.
  function automatic logic [7:0] top_vec(input logic [3:0] m, input logic [31:0] vs);
    logic [7:0] r;
    r = 8'h00;
    for (int i = N - 1; i >= 0; i--) begin
      if (m[i]) begin
        r = vs[i*8+:8];
      end
    end
    return r;
  endfunction

  task automatic pulse(input logic [3:0] m);
    @(posedge clk_sys_i) ev <= m;
    @(posedge clk_sys_i) ev <= 4'h0;
  endtask

  task automatic wait_vv;
    for (int i = 0; i < 60; i++) begin
      @(posedge clk_sys_i);
      if (vv === 1'b1) break;
    end
    chk({7'h0, vv}, 8'h01);
  endtask

  always @(posedge clk_sys_i) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      conclude();
    end
  end

  // Acknowledge shape: the fetch stands five clocks, the I/O strobe two, no memory strobe.
  always @(posedge clk_sys_i) begin
    if (fetch === 1'b1) begin
      fcnt++;
      if (io === 1'b1) iocnt++;
      chk({7'h0, mem}, 8'h00);
    end else if (rst_n_i === 1'b1) begin
      chk({7'h0, mem}, {7'h0, memory_request_strobe});
    end
    if (vv === 1'b1) begin
      chk(8'(fcnt), 8'h05);
      chk(8'(iocnt), 8'h02);
      fcnt = 0;
      iocnt = 0;
    end
  end

  // ------------------------------------------------------------
  // Stimulus
  // ------------------------------------------------------------
  initial begin
    logic [3:0] mask;
    logic [31:0] v;
    logic [3:0] left;
    void'($urandom(32'hbbf74a1c));
    repeat (16) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    @(posedge clk_sys_i);
    chk({6'h0, main, shadow}, 8'h00);
    chk({7'h0, chain}, 8'h01);
    // A request seen while the clock enable is low must leave no trace.
    ce <= 1'b0;
    req <= 4'h1;
    @(posedge clk_sys_i) req <= '0;
    @(posedge clk_sys_i) ce <= 1'b1;
    chk({7'h0, irq}, 8'h00);
    for (int r = 0; r < 6; r++) begin
      mask = 4'($urandom);
      if (r == 0 || mask == 4'h0) mask = 4'hf;
      v = $urandom & 32'hfefefefe;
      left = mask;
      @(posedge clk_sys_i);
      vecs_in <= v;
      req <= mask;
      @(posedge clk_sys_i) req <= '0;
      // Enable and disable together must leave requests masked.
      pulse(4'h3);
      repeat (8) @(posedge clk_sys_i);
      chk({7'h0, irq}, 8'h01);
      chk({7'h0, fetch}, 8'h00);
      chk({6'h0, main, shadow}, 8'h00);
      chk({7'h0, chain}, 8'h00);
      for (int k = 0; k < N; k++) begin
        if (mask[k]) begin
          pulse(4'h1);
          wait_vv();
          chk(vec, top_vec(left, v));
          left[k] = 1'b0;
          chk({7'h0, chain}, 8'h00);
          pulse(4'h8);
        end
      end
      repeat (2) @(posedge clk_sys_i);
      chk({7'h0, chain}, 8'h01);
      chk({7'h0, irq}, 8'h00);
    end
    pulse(4'h1);
    @(posedge clk_sys_i) nmi <= 1'b1;
    for (int i = 0; i < 20; i++) begin
      @(posedge clk_sys_i);
      if (take === 1'b1) break;
    end
    nmi <= 1'b0;
    chk({7'h0, take}, 8'h01);
    @(posedge clk_sys_i);
    chk({6'h0, main, shadow}, 8'h01);
    pulse(4'h4);
    @(posedge clk_sys_i);
    chk({6'h0, main, shadow}, 8'h03);
    conclude();
  end
endmodule
